// [logic/ulms_defines.svh]
/*
 * Offsets, field positions and reset values of the line and modem status block.
 * Assumes a byte-addressed register port of eight address bits.
 */
`ifndef ULMS_DEFINES_SVH
`define ULMS_DEFINES_SVH

// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define ULMS_AW 8
`define ULMS_OFF_MCTL 8'h10
`define ULMS_OFF_LSR 8'h14
`define ULMS_OFF_MSR 8'h18
`define ULMS_OFF_SCR 8'h1c
`define ULMS_OFF_CTRL 8'h40

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define ULMS_RST_BYTE 8'h00
`define ULMS_RST_PINS 4'hf
`define ULMS_RST_NONE 4'h0

// -----------------------------------------------------------------------------
// modem control fields
// -----------------------------------------------------------------------------
`define ULMS_MC_DTR 0
`define ULMS_MC_RTS 1
`define ULMS_MC_AUX_OUTPUT_ONE 2
`define ULMS_MC_AUX_OUTPUT_TWO 3
`define ULMS_MC_LOOP 4
`define ULMS_MC_W 5
`define ULMS_MC_PINS 3

// -----------------------------------------------------------------------------
// block control fields
// -----------------------------------------------------------------------------
`define ULMS_CT_FIFO 0
`define ULMS_CT_PAR 1
`define ULMS_CT_PEMPTY 2
`define ULMS_CT_RDA_EN 3
`define ULMS_CT_THR_EN 4
`define ULMS_CT_RLS_EN 5
`define ULMS_CT_W 6

// -----------------------------------------------------------------------------
// modem vector order and status field positions
// -----------------------------------------------------------------------------
`define ULMS_MV_CTS 0
`define ULMS_MV_DSR 1
`define ULMS_MV_RI 2
`define ULMS_MV_DCD 3
`define ULMS_LS_HOLDING_EMPTY_FLAG 5
`define ULMS_LS_DR 0
`define ULMS_MS_LVL_HI 7
`define ULMS_MS_LVL_LO 4
`define ULMS_ERR_SOLE 5'd1

`endif

// [logic/ulms_pkg.sv]
/*
 * Types shared by the line and modem status block.
 * Assumes the receive and transmit paths report their events on the system clock.
 */
package ulms_pkg;

    // receive path report, same clock domain
    typedef struct packed {
        logic arrive;
        logic arr_pe;
        logic arr_fe;
        logic arr_bi;
        logic head_adv;
        logic head_pe;
        logic head_fe;
        logic head_bi;
        logic nonempty;
        logic full;
        logic [4:0] err_count;
    } ulms_rx_type;

    // transmit path report, same clock domain
    typedef struct packed {
        logic write;
        logic drained;
        logic buf_empty;
        logic buf_full;
        logic shift_empty;
    } ulms_tx_type;

    // active-low modem inputs
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ulms_min_type;

    // active-low modem outputs
    typedef struct packed {
        logic aux_output_two_n;
        logic aux_output_one_n;
        logic rts_n;
        logic dtr_n;
    } ulms_mout_type;

    // interrupt request levels
    typedef struct packed {
        logic line_status;
        logic rx_data;
        logic holding_empty;
    } ulms_irq_type;

    // whole state of the block
    typedef struct packed {
        logic [7:0] scratch;
        logic [4:0] mctl;
        logic [5:0] ctrl;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] pin_st;
        logic [3:0] prev_eff;
        logic [3:0] delta;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic fifo_err;
        logic transmitter_empty_flag;
        logic holding_empty_flag;
        logic [7:0] rdata;
        logic [3:0] mout;
        logic [2:0] irq;
    } ulms_state_type;

endpackage : ulms_pkg

// [logic/ulms_status_regs.sv]
/*
 * Line status, modem status, modem control and scratch registers of a UART.
 * Assumes receive/transmit FIFOs and the receiver report events on i_clk_sys;
 * modem pins are asynchronous and are synchronised here.
 */
`timescale 1ns/100ps
`include "ulms_defines.svh"

module ulms_status_regs (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // register port
    input wire logic [`ULMS_AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // receive and transmit path reports
    input wire ulms_pkg::ulms_rx_type i_rx,
    input wire ulms_pkg::ulms_tx_type i_tx,
    // modem pins
    input wire ulms_pkg::ulms_min_type i_min,
    output ulms_pkg::ulms_mout_type o_mout,
    // control levels and interrupt requests
    output logic o_fifo_en,
    output logic o_loopback,
    output ulms_pkg::ulms_irq_type o_irq
);
    import ulms_pkg::*;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    // register decode, shared by reads, writes and checks
    function automatic logic ulms_hit(input logic [`ULMS_AW-1:0] a,
                                      input logic [`ULMS_AW-1:0] off);
        ulms_hit = (a == off);
    endfunction : ulms_hit

    // modem levels in asserted-high form, order dcd, ri, dsr, cts
    function automatic logic [3:0] ulms_eff(input logic [`ULMS_MC_W-1:0] mc,
                                            input logic [3:0] pins);
        if (mc[`ULMS_MC_LOOP]) begin
            ulms_eff = {mc[`ULMS_MC_AUX_OUTPUT_TWO], mc[`ULMS_MC_AUX_OUTPUT_ONE],
                        mc[`ULMS_MC_DTR], mc[`ULMS_MC_RTS]};
        end else begin
            ulms_eff = ~pins;
        end
    endfunction : ulms_eff

    // change detect; ring counts only one edge direction
    function automatic logic [3:0] ulms_chg(input logic [3:0] eff,
                                            input logic [3:0] prev,
                                            input logic loop);
        logic [3:0] c;
        c = eff ^ prev;
        if (loop) begin
            c[`ULMS_MV_RI] = ~eff[`ULMS_MV_RI] & prev[`ULMS_MV_RI];
        end else begin
            c[`ULMS_MV_RI] = eff[`ULMS_MV_RI] & ~prev[`ULMS_MV_RI];
        end
        ulms_chg = c;
    endfunction : ulms_chg

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    ulms_state_type state_r;
    ulms_state_type state_nxt;

    // next-state logic for every register of the block
    always_comb begin
        logic lsr_rd;
        logic msr_rd;
        logic fifo_en;
        logic par_en;
        logic pempty;
        logic [3:0] eff;
        logic [3:0] stable_diff;
        logic fe_set;
        logic pe_set;
        logic bi_set;
        logic oe_set;
        logic ferr_set;
        logic ferr_clr;
        logic holding_empty_flag_view;
        fe_set = 1'b0;
        pe_set = 1'b0;
        bi_set = 1'b0;
        oe_set = 1'b0;
        lsr_rd = i_rd && ulms_hit(i_addr, `ULMS_OFF_LSR);
        msr_rd = i_rd && ulms_hit(i_addr, `ULMS_OFF_MSR);
        fifo_en = state_r.ctrl[`ULMS_CT_FIFO];
        par_en = state_r.ctrl[`ULMS_CT_PAR];
        pempty = state_r.ctrl[`ULMS_CT_PEMPTY];
        eff = ulms_eff(state_r.mctl, state_r.pin_st);
        stable_diff = state_r.s2 ^ state_r.s3;
        state_nxt = state_r;

        // software writes; scratch has no side effect at all
        if (i_wr && ulms_hit(i_addr, `ULMS_OFF_SCR)) begin
            state_nxt.scratch = i_wdata;
        end
        if (i_wr && ulms_hit(i_addr, `ULMS_OFF_MCTL)) begin
            state_nxt.mctl = i_wdata[`ULMS_MC_W-1:0];
        end
        if (i_wr && ulms_hit(i_addr, `ULMS_OFF_CTRL)) begin
            state_nxt.ctrl = i_wdata[`ULMS_CT_W-1:0];
        end

        // three-stage pin synchroniser; a level counts once stages 2 and 3 agree
        state_nxt.s1 = i_min;
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
        state_nxt.pin_st = (~stable_diff & state_r.s3) | (stable_diff & state_r.pin_st);

        // change flags: set beats the clearing read so no edge is lost
        state_nxt.prev_eff = eff;
        state_nxt.delta = ulms_chg(eff, state_r.prev_eff, state_r.mctl[`ULMS_MC_LOOP])
                        | (state_r.delta & {4{~msr_rd}});

        // output pins held high in loopback
        if (state_r.mctl[`ULMS_MC_LOOP]) begin
            state_nxt.mout = `ULMS_RST_PINS;
        end else begin
            state_nxt.mout = ~state_r.mctl[`ULMS_MC_PINS:0];
        end

        // error flags: fe, pe and bi from head entry with FIFO, arriving character without
        if (fifo_en) begin
            fe_set = i_rx.head_adv & i_rx.head_fe;
            pe_set = i_rx.head_adv & i_rx.head_pe & par_en;
            bi_set = i_rx.head_adv & i_rx.head_bi;
            oe_set = i_rx.arrive & i_rx.full;
        end else begin
            fe_set = i_rx.arrive & i_rx.arr_fe;
            pe_set = i_rx.arrive & i_rx.arr_pe & par_en;
            bi_set = i_rx.arrive & i_rx.arr_bi;
            oe_set = i_rx.arrive & i_rx.nonempty;
        end
        state_nxt.fe = fe_set | (state_r.fe & ~lsr_rd);
        state_nxt.pe = pe_set | (state_r.pe & ~lsr_rd);
        state_nxt.bi = bi_set | (state_r.bi & ~lsr_rd);
        state_nxt.oe = oe_set | (state_r.oe & ~lsr_rd);

        // fifo error: a read clears only the sole remaining bad entry
        ferr_set = i_rx.arrive & (i_rx.arr_fe | i_rx.arr_bi | (i_rx.arr_pe & par_en));
        ferr_clr = lsr_rd && (i_rx.err_count <= `ULMS_ERR_SOLE);
        state_nxt.fifo_err = fifo_en & (ferr_set | (state_r.fifo_err & ~ferr_clr));

        // transmitter states; a data write always wins
        state_nxt.transmitter_empty_flag = ~i_tx.write & i_tx.buf_empty & i_tx.shift_empty;
        // only a drain by transmission sets holding-empty, never a flush
        state_nxt.holding_empty_flag = ~i_tx.write & (i_tx.drained | state_r.holding_empty_flag);
        holding_empty_flag_view = pempty ? i_tx.buf_full : state_r.holding_empty_flag;

        // interrupt request levels
        state_nxt.irq[2] = state_r.ctrl[`ULMS_CT_RLS_EN]
                         & (state_r.oe | state_r.pe | state_r.fe | state_r.bi);
        state_nxt.irq[1] = state_r.ctrl[`ULMS_CT_RDA_EN] & i_rx.nonempty;
        state_nxt.irq[0] = state_r.ctrl[`ULMS_CT_THR_EN] & state_r.holding_empty_flag & ~pempty;

        // read data stands for one cycle after the read strobe
        state_nxt.rdata = `ULMS_RST_BYTE;
        if (i_rd) begin
            case (i_addr)
                `ULMS_OFF_LSR: state_nxt.rdata = {state_r.fifo_err, state_r.transmitter_empty_flag,
                                                  holding_empty_flag_view, state_r.bi, state_r.fe,
                                                  state_r.pe, state_r.oe,
                                                  i_rx.nonempty};
                `ULMS_OFF_MSR: state_nxt.rdata = {eff, state_r.delta};
                `ULMS_OFF_SCR: state_nxt.rdata = state_r.scratch;
                `ULMS_OFF_MCTL: state_nxt.rdata = {3'h0, state_r.mctl};
                `ULMS_OFF_CTRL: state_nxt.rdata = {2'h0, state_r.ctrl};
                default: state_nxt.rdata = `ULMS_RST_BYTE;
            endcase
        end
    end

    // single register bank; synchroniser stages reset to the idle pin level
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= '0;
            state_r.s1 <= `ULMS_RST_PINS;
            state_r.s2 <= `ULMS_RST_PINS;
            state_r.s3 <= `ULMS_RST_PINS;
            state_r.pin_st <= `ULMS_RST_PINS;
            state_r.mout <= `ULMS_RST_PINS;
            state_r.prev_eff <= `ULMS_RST_NONE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    // all from flops
    assign o_rdata = state_r.rdata;
    assign o_mout = state_r.mout;
    assign o_fifo_en = state_r.ctrl[`ULMS_CT_FIFO];
    assign o_loopback = state_r.mctl[`ULMS_MC_LOOP];
    assign o_irq = state_r.irq;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    logic lsr_rd_c;
    logic msr_rd_c;
    assign lsr_rd_c = i_rd && ulms_hit(i_addr, `ULMS_OFF_LSR);
    assign msr_rd_c = i_rd && ulms_hit(i_addr, `ULMS_OFF_MSR);

    a_dtr_loop_high: assert property (
        state_r.mctl[`ULMS_MC_LOOP] |=> o_mout.dtr_n)
        else $error("dtr pin not high in loopback");
    a_dtr_normal: assert property (
        !state_r.mctl[`ULMS_MC_LOOP] |=> o_mout.dtr_n == !$past(state_r.mctl[`ULMS_MC_DTR]))
        else $error("dtr pin not inverse of control bit");
    a_ferr_no_fifo: assert property (
        !o_fifo_en |=> !state_r.fifo_err)
        else $error("fifo error set without fifo buffering");
    a_ferr_keeps: assert property (
        (lsr_rd_c && state_r.fifo_err && o_fifo_en && i_rx.err_count > `ULMS_ERR_SOLE)
        |=> state_r.fifo_err)
        else $error("fifo error cleared while other bad entries remain");
    a_transmitter_empty_flag_write: assert property (
        i_tx.write |=> !state_r.transmitter_empty_flag)
        else $error("transmitter empty after data write");
    a_holding_empty_flag_cause: assert property (
        $rose(state_r.holding_empty_flag) |-> $past(i_tx.drained))
        else $error("holding empty set without drain");
    a_holding_empty_flag_full_view: assert property (
        (lsr_rd_c && state_r.ctrl[`ULMS_CT_PEMPTY])
        |=> o_rdata[`ULMS_LS_HOLDING_EMPTY_FLAG] == $past(i_tx.buf_full))
        else $error("bit 5 not full indication");
    a_overrun_set: assert property (
        (i_rx.arrive && !o_fifo_en && i_rx.nonempty) |=> ##[0:2] state_r.oe)
        else $error("overrun missed");
    a_fe_survives: assert property (
        (lsr_rd_c && i_rx.arrive && i_rx.arr_fe && !o_fifo_en) |=> state_r.fe)
        else $error("framing error lost at clearing read");
    a_dr_read: assert property (
        lsr_rd_c |=> o_rdata[`ULMS_LS_DR] == $past(i_rx.nonempty))
        else $error("data ready mismatch");
    a_msr_levels: assert property (
        msr_rd_c |=> o_rdata[`ULMS_MS_LVL_HI:`ULMS_MS_LVL_LO]
                     == $past(ulms_eff(state_r.mctl, state_r.pin_st)))
        else $error("modem levels mismatch");
    a_msr_clear: assert property (
        (msr_rd_c && ulms_chg(ulms_eff(state_r.mctl, state_r.pin_st), state_r.prev_eff,
                              state_r.mctl[`ULMS_MC_LOOP]) == 4'h0)
        |=> state_r.delta == 4'h0)
        else $error("change flags survive status read");
    a_scratch_rw: assert property (
        (i_wr && ulms_hit(i_addr, `ULMS_OFF_SCR)) ##1
        (i_rd && !i_wr && ulms_hit(i_addr, `ULMS_OFF_SCR))
        |=> o_rdata == $past(i_wdata, 2))
        else $error("scratch readback wrong");

    c_loop_ring: cover property (
        state_r.mctl[`ULMS_MC_LOOP] ##1 state_r.delta[`ULMS_MV_RI]);
    c_fifo_err_read: cover property (lsr_rd_c && state_r.fifo_err);
    c_overrun: cover property ($rose(state_r.oe));
    c_pin_change: cover property (!state_r.mctl[`ULMS_MC_LOOP] && $rose(state_r.delta[0]));

endmodule : ulms_status_regs

// [tb/testbench.sv]
/*
 * Self-checking bench of the line and modem status registers.
 * Assumes the far-side model drives pins and path reports; bench owns the register port.
 */
`timescale 1ns/100ps
`include "ulms_defines.svh"

module testbench;
    import ulms_pkg::*;

    logic i_clk_sys;
    logic i_nrst;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    ulms_min_type i_min;
    ulms_rx_type i_rx;
    ulms_tx_type i_tx;
    ulms_mout_type o_mout;
    logic o_fifo_en;
    logic o_loopback;
    ulms_irq_type o_irq;
    logic [7:0] got;
    int err_count;
    int num_checks;

    ulms_status_regs dut_u (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx(i_rx), .i_tx(i_tx),
        .i_min(i_min), .o_mout(o_mout), .o_fifo_en(o_fifo_en), .o_loopback(o_loopback),
        .o_irq(o_irq)
    );

    ulms_far_model far_u (.i_clk_sys(i_clk_sys), .o_min(i_min), .o_rx(i_rx), .o_tx(i_tx));

    // 200 MHz system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    // -------------------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------------------
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk_byte

    task automatic chk_pin(input string what, input logic [3:0] exp, input logic [3:0] seen);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk_pin

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : idle

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        got = o_rdata;
    endtask : rd_reg

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd_reg(a);
        chk_byte(what, exp, got);
    endtask : rd_chk

    task automatic test_end(input string name);
        $display("test %s done", name);
    endtask : test_end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // -------------------------------------------------------------------------
    // tests
    // -------------------------------------------------------------------------
    initial begin
        i_nrst = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (20) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        idle(1);
        chk_pin("mout", 4'hf, o_mout);
        chk_pin("fifo_irq", 4'h0, {o_fifo_en, o_irq});
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h00);
        rd_chk("msr", `ULMS_OFF_MSR, 8'h00);
        rd_chk("scr", `ULMS_OFF_SCR, 8'h00);
        rd_chk("unmapped", 8'h44, 8'h00);
        test_end("reset");
        // writes to read-only and unmapped places must not reach the scratch byte
        wr_reg(`ULMS_OFF_SCR, 8'h5a);
        wr_reg(8'h44, 8'hff);
        wr_reg(`ULMS_OFF_LSR, 8'hff);
        rd_chk("scr", `ULMS_OFF_SCR, 8'h5a);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h00);
        wr_reg(`ULMS_OFF_SCR, 8'ha5);
        rd_chk("scr", `ULMS_OFF_SCR, 8'ha5);
        test_end("scratch");
        wr_reg(`ULMS_OFF_MCTL, 8'h01);
        idle(2);
        chk_pin("mout", 4'he, o_mout);
        wr_reg(`ULMS_OFF_MCTL, 8'h03);
        idle(2);
        chk_pin("mout", 4'hc, o_mout);
        // software trusts these modem bits only in loopback
        wr_reg(`ULMS_OFF_MCTL, 8'h1f);
        idle(4);
        chk_pin("mout", 4'hf, o_mout);
        rd_reg(`ULMS_OFF_MSR);
        rd_chk("msr", `ULMS_OFF_MSR, 8'hf0);
        wr_reg(`ULMS_OFF_MCTL, 8'h1b);
        idle(4);
        rd_chk("msr", `ULMS_OFF_MSR, 8'hb4);
        wr_reg(`ULMS_OFF_MCTL, 8'h12);
        idle(4);
        rd_chk("msr", `ULMS_OFF_MSR, 8'h1a);
        wr_reg(`ULMS_OFF_MCTL, 8'h10);
        idle(4);
        rd_chk("msr", `ULMS_OFF_MSR, 8'h01);
        wr_reg(`ULMS_OFF_MCTL, 8'h14);
        idle(4);
        rd_chk("msr", `ULMS_OFF_MSR, 8'h40);
        test_end("loopback");
        // leaving loopback may flag changes, so flush them first
        wr_reg(`ULMS_OFF_MCTL, 8'h00);
        idle(8);
        rd_reg(`ULMS_OFF_MSR);
        rd_chk("msr", `ULMS_OFF_MSR, 8'h00);
        far_u.set_pins(4'h0, 3);
        idle(8);
        rd_chk("msr", `ULMS_OFF_MSR, 8'hff);
        rd_chk("msr", `ULMS_OFF_MSR, 8'hf0);
        far_u.set_pins(4'h4, 0);
        idle(8);
        rd_chk("msr", `ULMS_OFF_MSR, 8'hb0);
        test_end("pins");
        // rx word: arrive pe fe bi, head_adv pe fe bi, nonempty full, error count
        wr_reg(`ULMS_OFF_CTRL, 8'h2a);
        // arrival into an empty buffer, then the buffer reports data present
        far_u.rx_evt({4'b1111, 4'h0, 2'b00, 5'd0});
        far_u.rx_evt({4'b0000, 4'h0, 2'b10, 5'd0});
        idle(2);
        chk_pin("irq", 4'h6, {1'b0, o_irq});
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h1d);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h01);
        idle(2);
        chk_pin("irq", 4'h2, {1'b0, o_irq});
        far_u.rx_evt({4'b1000, 4'h0, 2'b11, 5'd0});
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h03);
        wr_reg(`ULMS_OFF_CTRL, 8'h28);
        // buffer still unread, so this arrival overruns; parity is off
        far_u.rx_evt({4'b1100, 4'h0, 2'b10, 5'd0});
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h03);
        // framing error lands on the clearing read's edge
        fork
            rd_chk("lsr", `ULMS_OFF_LSR, 8'h01);
            far_u.rx_evt({4'b1010, 4'h0, 2'b10, 5'd0});
        join
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h0b);
        far_u.rx_evt({4'b0000, 4'h0, 2'b00, 5'd0});
        idle(2);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h00);
        chk_pin("irq", 4'h0, {1'b0, o_irq});
        test_end("line");
        wr_reg(`ULMS_OFF_CTRL, 8'h03);
        idle(1);
        chk_pin("fifo", 4'h1, {3'b000, o_fifo_en});
        far_u.rx_evt({4'b1001, 4'b1010, 2'b10, 5'd2});
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h89);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h81);
        far_u.rx_evt({4'b0000, 4'h0, 2'b10, 5'd1});
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h81);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h01);
        far_u.rx_evt({4'b1010, 4'h0, 2'b10, 5'd1});
        wr_reg(`ULMS_OFF_CTRL, 8'h00);
        idle(1);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h01);
        test_end("fifo");
        // tx word: write drained buf_empty buf_full shift_empty
        wr_reg(`ULMS_OFF_CTRL, 8'h10);
        far_u.tx_evt(5'b01101);
        idle(2);
        chk_pin("irq", 4'h1, {1'b0, o_irq});
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h61);
        far_u.tx_evt(5'b10000);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h01);
        far_u.tx_evt(5'b00100);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h01);
        wr_reg(`ULMS_OFF_CTRL, 8'h14);
        far_u.tx_evt(5'b00010);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h21);
        chk_pin("irq", 4'h0, {1'b0, o_irq});
        far_u.tx_evt(5'b00000);
        rd_chk("lsr", `ULMS_OFF_LSR, 8'h01);
        test_end("transmit");
        wrap_up();
    end

    // whole run needs under a thousand cycles; twenty thousand means a hang
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end

endmodule : testbench

// [tb/ulms_far_model.sv]
/*
 * Far-side model of the status block: modem pins and receive/transmit path reports.
 * Assumes the bench calls its tasks on the system clock, one call per signal group at a time.
 */
`timescale 1ns/100ps

module ulms_far_model (
    // clock
    input wire logic i_clk_sys,
    // toward the status block
    output ulms_pkg::ulms_min_type o_min,
    output ulms_pkg::ulms_rx_type o_rx,
    output ulms_pkg::ulms_tx_type o_tx
);
    import ulms_pkg::*;

    // -------------------------------------------------------------------------
    // drivers
    // -------------------------------------------------------------------------
    // idle line: modem pins inactive high, transmit buffer still busy
    initial begin
        o_min = 4'hf;
        o_rx = '0;
        o_tx = '0;
    end

    // pins move after an optional lag, as a slow modem would
    task automatic set_pins(input ulms_min_type v, input int lag);
        repeat (lag) @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        o_min <= v;
    endtask : set_pins

    // event pulses last one cycle; levels and qualifiers stay put
    task automatic rx_evt(input ulms_rx_type v);
        @(posedge i_clk_sys);
        o_rx <= v;
        @(posedge i_clk_sys);
        o_rx.arrive <= 1'b0;
        o_rx.head_adv <= 1'b0;
    endtask : rx_evt

    // write and drained are pulses, buffer levels hold
    task automatic tx_evt(input ulms_tx_type v);
        @(posedge i_clk_sys);
        o_tx <= v;
        @(posedge i_clk_sys);
        o_tx.write <= 1'b0;
        o_tx.drained <= 1'b0;
    endtask : tx_evt

endmodule : ulms_far_model
